//--- rtl/apm_pkg.sv
// Purpose: shared constants and types of the accelerometer power-mode control
// Assumes: register port and sensing front end run from mclk
// Notes: all offsets and timing figures live here, and every field position except those of the power status register
package apm_pkg;
  // clock and output data rate timing
  localparam int CLK_HZ = 25_000_000;
  localparam int BASE_HZ = 6400; // twice the fastest output data rate
  localparam int BASE_CYCLES = CLK_HZ / BASE_HZ; // rounds down: slightly short tick spacing
  localparam int PRE_W = 13;
  localparam int CNT_W = 17;
  localparam logic [3:0] RATE_CODE_MAX = 4'h0_00F; // code of the 3200 Hz rate
  localparam logic [4:0] RATE_EXP_TOP = 5'h0_010; // exponent for code 0000
  localparam logic [3:0] SLEEP_RATE_CODE = 4'h0_005; // a rate below 8 Hz
  localparam logic [2:0] SETTLE_PERIODS = 3'h0_004; // data periods after self-test change

  // register addresses and widths
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam logic [5:0] ADDR_INACT_LEVEL = 6'h0_025;
  localparam logic [5:0] ADDR_INACT_DURATION = 6'h0_026;
  localparam logic [5:0] ADDR_SPEED_SELECT = 6'h0_02C;
  localparam logic [5:0] ADDR_POWER_CONTROL = 6'h0_02D;
  localparam logic [5:0] ADDR_POWER_STATUS = 6'h0_03E;

  // field positions
  localparam int SPEED_LOW_POWER_BIT = 4;
  localparam int SPEED_RATE_LSB = 0;
  localparam int PWR_MEASURE_BIT = 3;
  localparam int PWR_AUTOSLEEP_BIT = 4;
  localparam int PWR_LINK_BIT = 5;

  // reset values
  localparam logic [7:0] INACT_LEVEL_RST = 8'h0_000;
  localparam logic [7:0] INACT_DURATION_RST = 8'h0_000;
  localparam logic [7:0] SPEED_SELECT_RST = 8'h0_000;
  localparam logic [7:0] POWER_CONTROL_RST = 8'h0_000;
  localparam logic [7:0] DATA_ZERO = 8'h0_000;

  typedef enum logic [1:0] {
    APM_STANDBY,
    APM_MEASURE,
    APM_SLEEP
  } apm_mode_t;
endpackage

//--- rtl/apm_power_ctrl.sv
// Purpose: power-mode control of a three-axis accelerometer
// Assumes: register port driven by serial interface logic clocked by mclk; interface supply flag is a pin
// Notes: sample FIFO lives outside; this block only gates sensing and paces conversions
//
// Operation
// R1: after power-up sit in standby, waiting for interface supply and measure command
// R2: all sensing stays off in standby until measurement is commanded
// R3: setting measure bit D3 of power_control at 0x2D starts measurement
// R4: clearing the measure bit returns the device to standby
// R5: every register stays readable and writable while in standby
// R6: host should configure in standby, then enable measurement
// R7: standby makes no acceleration measurements
// R8: entering standby leaves the sample FIFO contents untouched
// R9: bit D4 of sample_speed_select at 0x2C selects low-power mode
// R10: low-power mode lowers the internal sampling rate
// R11: rate code 1111 is 3200 Hz, halving per step to 0.10 Hz
// R12: host should use low power only with rate codes 1100 to 0111
// R13: autosleep enters sleep after inactivity judged by registers 0x25 and 0x26
// R14: host programs inactivity registers, then sets autosleep D4 and link D5
// R15: while autosleeping, sample at a rate below 8 Hz
// R16: self-test needs normal power; output settles four data periods after change
// R17: rate code is a four-bit field; all sixteen values are valid
`timescale 1ns/1ps
`default_nettype none
module apm_power_ctrl
  import apm_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic io_supply_ok,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [apm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [apm_pkg::DATA_W-1:0] reg_wdata,
  input wire logic [apm_pkg::DATA_W-1:0] activity_mag,
  input wire logic self_test_req,
  output logic [apm_pkg::DATA_W-1:0] reg_rdata,
  output logic sensing_active,
  output logic conv_strobe,
  output logic data_ready,
  output logic low_power_active,
  output logic self_test_drive,
  output logic self_test_settled,
  output apm_pkg::apm_mode_t mode_state
);
  import apm_pkg::*;

  typedef struct packed {
    logic io_s1;
    logic io_s2;
    logic io_s3;
    logic io_ok;
    logic [DATA_W-1:0] inact_level;
    logic [DATA_W-1:0] inact_duration;
    logic [DATA_W-1:0] speed_select;
    logic [DATA_W-1:0] power_control;
    logic [DATA_W-1:0] rdata;
    apm_mode_t mode;
    logic [DATA_W-1:0] inact_cnt;
    logic st_prev;
    logic [2:0] settle;
    logic settled;
    logic sensing;
    logic conv;
    logic drdy;
    logic lp;
    logic st_drive;
  } apm_ctl_t;

  apm_ctl_t r;
  apm_ctl_t next_r;
  logic tmr_conv;
  logic tmr_odr;
  logic tmr_run;
  logic [3:0] tmr_code;
  logic measure_bit;
  logic autosleep_armed;
  logic quiet;
  logic [DATA_W-1:0] cnt_inc;

  assign measure_bit = r.power_control[PWR_MEASURE_BIT];
  assign autosleep_armed = r.power_control[PWR_AUTOSLEEP_BIT] && r.power_control[PWR_LINK_BIT];
  assign quiet = (activity_mag <= r.inact_level);
  assign cnt_inc = (r.inact_cnt == {DATA_W{1'b1}}) ? r.inact_cnt : r.inact_cnt + DATA_W'(1);

  // the timer halts in standby, so no conversion is paced there
  assign tmr_run = (r.mode != APM_STANDBY); // R2 R7
  // asleep the timer runs at the fixed slow code, not the user rate
  assign tmr_code = (r.mode == APM_SLEEP) ? SLEEP_RATE_CODE
                                          : r.speed_select[SPEED_RATE_LSB +: 4]; // R11 R15 R17

  apm_rate_timer #(
    .BASE_DIV(BASE_CYCLES)
  ) u_rate_timer (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .run(tmr_run),
    .low_power(r.speed_select[SPEED_LOW_POWER_BIT]), // R9
    .rate_code(tmr_code),
    .conv_tick(tmr_conv),
    .odr_tick(tmr_odr)
  );

  always_comb begin
    next_r = r;

    // interface supply flag: a change counts once the second and third stages agree
    next_r.io_s1 = io_supply_ok;
    next_r.io_s2 = r.io_s1;
    next_r.io_s3 = r.io_s2;
    if (r.io_s2 == r.io_s3) begin
      next_r.io_ok = r.io_s3;
    end

    // register port: no access without interface supply; mode never blocks it
    next_r.rdata = r.rdata;
    if (r.io_ok && reg_wr) begin // R5
      if (reg_addr == ADDR_INACT_LEVEL) begin
        next_r.inact_level = reg_wdata;
      end else if (reg_addr == ADDR_INACT_DURATION) begin
        next_r.inact_duration = reg_wdata;
      end else if (reg_addr == ADDR_SPEED_SELECT) begin
        next_r.speed_select = reg_wdata; // R9 R17
      end else if (reg_addr == ADDR_POWER_CONTROL) begin
        next_r.power_control = reg_wdata; // R3 R4
      end
    end
    if (r.io_ok && reg_rd) begin // R5
      if (reg_addr == ADDR_INACT_LEVEL) begin
        next_r.rdata = r.inact_level;
      end else if (reg_addr == ADDR_INACT_DURATION) begin
        next_r.rdata = r.inact_duration;
      end else if (reg_addr == ADDR_SPEED_SELECT) begin
        next_r.rdata = r.speed_select;
      end else if (reg_addr == ADDR_POWER_CONTROL) begin
        next_r.rdata = r.power_control;
      end else if (reg_addr == ADDR_POWER_STATUS) begin
        next_r.rdata = {3'b000, r.st_drive, (r.settle == 3'b000), r.lp, r.mode};
      end else begin
        next_r.rdata = DATA_ZERO;
      end
    end

    // mode sequencing; the sample FIFO is outside and standby issues no flush to it
    case (r.mode)
      APM_STANDBY: begin
        next_r.inact_cnt = '0;
        if (measure_bit && r.io_ok) begin // R1 R3
          next_r.mode = APM_MEASURE;
        end
      end
      APM_MEASURE: begin
        if (!measure_bit) begin
          next_r.mode = APM_STANDBY; // R4 R8
        end else if (tmr_odr) begin
          // each quiet sample extends the run; any active sample restarts it
          next_r.inact_cnt = quiet ? cnt_inc : '0;
          if (autosleep_armed && quiet && cnt_inc >= r.inact_duration) begin // R13
            next_r.mode = APM_SLEEP;
            next_r.inact_cnt = '0;
          end
        end
      end
      APM_SLEEP: begin
        if (!measure_bit) begin
          next_r.mode = APM_STANDBY; // R4 R8
        end else if (!autosleep_armed) begin
          next_r.mode = APM_MEASURE;
        end else if (tmr_odr && !quiet) begin
          next_r.mode = APM_MEASURE; // R13
        end
      end
      default: begin
        next_r.mode = APM_STANDBY;
      end
    endcase

    // self-test settling counts data ticks after each change; the first period can be partial
    next_r.st_prev = self_test_req;
    if (self_test_req != r.st_prev) begin
      next_r.settle = SETTLE_PERIODS; // R16
    end else if (tmr_odr && r.settle != 3'b000) begin
      next_r.settle = r.settle - 3'b001; // R16
    end
    // drive self-test only in normal power, where the response is trustworthy
    next_r.st_drive = self_test_req && !r.speed_select[SPEED_LOW_POWER_BIT] && tmr_run; // R16

    // outputs held in flip-flops
    next_r.sensing = tmr_run; // R2 R7
    next_r.conv = tmr_conv && tmr_run; // R7 R10
    next_r.drdy = tmr_odr && tmr_run; // R11
    next_r.lp = r.speed_select[SPEED_LOW_POWER_BIT]; // R9
    // registered copy of the settle decode, in step with the counter itself
    next_r.settled = (next_r.settle == 3'b000); // R16
  end

  // constants only under reset; the device wakes in standby
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '{
        io_s1: 1'b0,
        io_s2: 1'b0,
        io_s3: 1'b0,
        io_ok: 1'b0,
        inact_level: INACT_LEVEL_RST,
        inact_duration: INACT_DURATION_RST,
        speed_select: SPEED_SELECT_RST,
        power_control: POWER_CONTROL_RST,
        rdata: DATA_ZERO,
        mode: APM_STANDBY, // R1
        inact_cnt: DATA_ZERO,
        st_prev: 1'b0,
        settle: 3'b000,
        settled: 1'b1,
        sensing: 1'b0,
        conv: 1'b0,
        drdy: 1'b0,
        lp: 1'b0,
        st_drive: 1'b0
      };
    end else begin
      r <= next_r;
    end
  end

  assign reg_rdata = r.rdata;
  assign sensing_active = r.sensing;
  assign conv_strobe = r.conv;
  assign data_ready = r.drdy;
  assign low_power_active = r.lp;
  assign self_test_drive = r.st_drive;
  assign self_test_settled = r.settled;
  assign mode_state = r.mode;
endmodule
`default_nettype wire

//--- rtl/apm_rate_timer.sv
// Purpose: output data rate and internal conversion tick generator
// Assumes: rate code 0000..1111 maps 0.10 Hz..3200 Hz, halving per step
// Notes: ticks are one-cycle pulses from flip-flops
`timescale 1ns/1ps
`default_nettype none
module apm_rate_timer
  import apm_pkg::*;
#(
  parameter int BASE_DIV = apm_pkg::BASE_CYCLES
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic low_power,
  input wire logic [3:0] rate_code,
  output logic conv_tick,
  output logic odr_tick
);
  import apm_pkg::*;

  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [CNT_W-1:0] cnt;
    logic conv;
    logic odr;
  } apm_tmr_t;

  apm_tmr_t r;
  apm_tmr_t next_r;
  logic [4:0] rate_exp;
  logic [CNT_W-1:0] top;
  logic [CNT_W-1:0] half;
  logic wrap;

  // one base tick is half the 3200 Hz period, so top spans 2^(16-code) base ticks
  assign rate_exp = RATE_EXP_TOP - {1'b0, rate_code};
  assign top = (CNT_W'(1) << rate_exp) - CNT_W'(1);
  assign half = top >> 1;
  // greater-or-equal so a rate change to a shorter period wraps at once instead of running to overflow
  assign wrap = (r.cnt >= top);

  // prescaler and period counter; halted counters keep no stale phase
  always_comb begin
    next_r = r;
    next_r.conv = 1'b0;
    next_r.odr = 1'b0;
    if (!run) begin
      next_r.pre = '0;
      next_r.cnt = '0;
    end else if (r.pre == PRE_W'(BASE_DIV - 1)) begin
      next_r.pre = '0;
      next_r.odr = wrap;
      // normal mode converts twice per output period, low power only once
      next_r.conv = wrap || (!low_power && r.cnt == half); // R10
      next_r.cnt = wrap ? '0 : r.cnt + CNT_W'(1);
    end else begin
      next_r.pre = r.pre + PRE_W'(1);
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign conv_tick = r.conv;
  assign odr_tick = r.odr;
endmodule
`default_nettype wire

//--- sim/apm_host_model.sv
// Purpose: host side of the register port, byte reads and writes
// Assumes: requests change at falling edges and are taken at the next rising edge
// Notes: released data lines are inverted so a stale byte is never reused
`timescale 1ns/1ps
`default_nettype none
module apm_host_model
  import apm_pkg::*;
(
  input wire logic mclk,
  input wire logic [apm_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic [apm_pkg::ADDR_W-1:0] reg_addr,
  output logic [apm_pkg::DATA_W-1:0] reg_wdata
);
  // idle port at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
  end

  // one strobe cycle, qualifiers held across the taking edge
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_wdata = ~v;
  endtask

  // data is taken a full cycle after the strobe, it stands until the next read
  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    @(negedge mclk);
    v = reg_rdata;
  endtask
endmodule
`default_nettype wire

//--- sim/apm_power_ctrl_assertions.sv
// Purpose: port checker of the power-mode block
// Assumes: one clock domain, reset high
// Notes: io supply must have stood four cycles for a write to count
`timescale 1ns/1ps
`default_nettype none
module apm_power_ctrl_assertions
  import apm_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic io_supply_ok,
  input wire logic reg_wr,
  input wire logic [apm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [apm_pkg::DATA_W-1:0] reg_wdata,
  input wire logic self_test_req,
  input wire logic sensing_active,
  input wire logic conv_strobe,
  input wire logic data_ready,
  input wire logic low_power_active,
  input wire logic self_test_settled,
  input wire apm_pkg::apm_mode_t mode_state
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // accepted power_control write
  wire logic pc_wr = reg_wr && io_supply_ok && reg_addr == ADDR_POWER_CONTROL;

  property p_start; pc_wr && $past(io_supply_ok, 4) && reg_wdata[3] && mode_state == APM_STANDBY
    |-> ##2 mode_state == APM_MEASURE; endproperty
  a_start: assert property (p_start) else $error("measure not entered");
  property p_stop; pc_wr && $past(io_supply_ok, 4) && !reg_wdata[3] |-> ##2 mode_state == APM_STANDBY; endproperty
  a_stop: assert property (p_stop) else $error("standby not entered");
  property p_quiet; mode_state == APM_STANDBY && $past(mode_state) == APM_STANDBY |-> !data_ready && !conv_strobe;
  endproperty
  a_quiet: assert property (p_quiet) else $error("tick in standby");
  property p_sense; sensing_active |-> $past(mode_state) != APM_STANDBY; endproperty
  a_sense: assert property (p_sense) else $error("sensing in standby");
  property p_lp; reg_wr && io_supply_ok && $past(io_supply_ok, 4) && reg_addr == ADDR_SPEED_SELECT
    |-> ##2 low_power_active == $past(reg_wdata[4], 2); endproperty
  a_lp: assert property (p_lp) else $error("low power bit not applied");
  property p_lpconv; low_power_active && conv_strobe |-> data_ready; endproperty
  a_lpconv: assert property (p_lpconv) else $error("extra conversion in low power");
  property p_tick_once; data_ready |=> !data_ready; endproperty
  a_tick_once: assert property (p_tick_once) else $error("data tick too long");
  property p_st; $changed(self_test_req) |-> ##[0:2] !self_test_settled; endproperty
  a_st: assert property (p_st) else $error("settle not restarted");
endmodule
bind apm_power_ctrl apm_power_ctrl_assertions apm_power_ctrl_assertions_inst (.mclk, .sys_rst, .io_supply_ok,
  .reg_wr, .reg_addr, .reg_wdata, .self_test_req, .sensing_active, .conv_strobe, .data_ready, .low_power_active,
  .self_test_settled, .mode_state);
`default_nettype wire

//--- sim/apm_power_ctrl_tb.sv
// Purpose: self-checking bench of the power-mode block
// Assumes: fastest rate code keeps data periods short
// Notes: slow sleep rate is not timed, only entry and exit
`timescale 1ns/1ps
`default_nettype none
module apm_power_ctrl_tb;
  import apm_pkg::*;
  logic mclk, sys_rst, io_supply_ok, self_test_req, reg_wr, reg_rd;
  logic sensing_active, conv_strobe, data_ready, low_power_active, self_test_drive, self_test_settled;
  logic [5:0] reg_addr, a;
  logic [7:0] reg_wdata, reg_rdata, activity_mag, d, v;
  logic [5:0] addrs [5] = '{ADDR_INACT_LEVEL, ADDR_INACT_DURATION, ADDR_SPEED_SELECT, ADDR_POWER_CONTROL, 6'h10};
  apm_mode_t mode_state;
  int seed = 32'hfeaa8176;
  int error_cnt = 0;
  int samples_checked = 0;
  int gap, nconv, n;
  apm_power_ctrl apm_power_ctrl_inst (.mclk, .sys_rst, .io_supply_ok, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .activity_mag, .self_test_req, .reg_rdata, .sensing_active, .conv_strobe, .data_ready, .low_power_active,
    .self_test_drive, .self_test_settled, .mode_state);
  apm_host_model apm_host_model_inst (.mclk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // quiet front end: every sample stays under the inactivity level used below
  always @(negedge mclk) activity_mag <= 8'($random(seed)) & 8'h0F;
  function automatic int exp_gap(int code);
    return BASE_CYCLES << (16 - code);
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // bounded: first data tick, then one full period with its conversions
  task automatic period(output int g, output int c);
    for (n = 0; n < 40000 && data_ready !== 1'b1; n++) @(negedge mclk);
    g = 0;
    c = 0;
    do begin
      @(negedge mclk);
      g++;
      c += (conv_strobe !== 1'b0);
    end while (data_ready !== 1'b1 && g < 40000);
  endtask
  initial begin
    repeat (100000) @(posedge mclk);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    sys_rst = 1'b1;
    io_supply_ok = 1'b0;
    self_test_req = 1'b0;
    repeat (16) @(negedge mclk);
    sys_rst = 1'b0;
    apm_host_model_inst.wr(ADDR_POWER_CONTROL, 8'h08);
    repeat (4) @(negedge mclk);
    chk("mode_nosupply", mode_state, APM_STANDBY);
    io_supply_ok = 1'b1;
    repeat (6) @(negedge mclk);
    apm_host_model_inst.rd(ADDR_POWER_CONTROL, d);
    chk("pwr_dropped", d, 8'h00);
    for (int i = 0; i < 10; i++) begin
      a = addrs[i % 5];
      v = 8'($random(seed));
      if (a == ADDR_POWER_CONTROL) v = v & 8'hC7;
      if (a == ADDR_SPEED_SELECT && v[4]) v[3:0] = 4'h7 + 4'(v[3:0] % 6);
      apm_host_model_inst.wr(a, v);
      apm_host_model_inst.rd(a, d);
      chk("reg_rw", d, (a == 6'h10) ? 8'h00 : v);
    end
    chk("standby_sense", sensing_active, 1'b0);
    $display("test registers done");
    // configure first, then measure
    apm_host_model_inst.wr(ADDR_SPEED_SELECT, 8'h0F);
    apm_host_model_inst.wr(ADDR_POWER_CONTROL, 8'h08);
    period(gap, nconv);
    chk("odr_gap", gap, exp_gap(15));
    chk("conv_normal", nconv, 2);
    chk("sense_active", sensing_active, 1'b1);
    apm_host_model_inst.wr(ADDR_POWER_CONTROL, 8'h00);
    repeat (3) @(negedge mclk);
    chk("mode_stop", mode_state, APM_STANDBY);
    $display("test rate done");
    // corner: low power at the fastest code, outside the advised range, still halves conversions
    apm_host_model_inst.wr(ADDR_SPEED_SELECT, 8'h1F);
    apm_host_model_inst.wr(ADDR_POWER_CONTROL, 8'h08);
    self_test_req = 1'b1;
    period(gap, nconv);
    chk("conv_low_power", nconv, 1);
    chk("odr_gap_lp", gap, exp_gap(15));
    chk("lp_active", low_power_active, 1'b1);
    chk("st_blocked", self_test_drive, 1'b0);
    chk("st_settling", self_test_settled, 1'b0);
    apm_host_model_inst.wr(ADDR_SPEED_SELECT, 8'h0F);
    repeat (4) @(negedge mclk);
    chk("st_drive", self_test_drive, 1'b1);
    chk("lp_cleared", low_power_active, 1'b0);
    // two more data ticks complete the four settling periods
    period(gap, nconv);
    chk("odr_gap_st", gap, exp_gap(15));
    chk("conv_normal_st", nconv, 2);
    chk("st_settled", self_test_settled, 1'b1);
    $display("test low power done");
    // inactivity settings before autosleep and link
    apm_host_model_inst.wr(ADDR_INACT_LEVEL, 8'h10);
    apm_host_model_inst.wr(ADDR_INACT_DURATION, 8'h01);
    apm_host_model_inst.wr(ADDR_POWER_CONTROL, 8'h38);
    for (n = 0; n < 20000 && mode_state !== APM_SLEEP; n++) @(negedge mclk);
    chk("autosleep", mode_state, APM_SLEEP);
    apm_host_model_inst.wr(ADDR_POWER_CONTROL, 8'h18);
    repeat (3) @(negedge mclk);
    chk("link_off", mode_state, APM_MEASURE);
    apm_host_model_inst.rd(ADDR_POWER_STATUS, d);
    chk("status", d, {3'b000, 1'b1, 1'b1, 1'b0, 2'(APM_MEASURE)});
    apm_host_model_inst.wr(ADDR_POWER_CONTROL, 8'h00);
    gap = 0;
    repeat (10000) begin
      @(negedge mclk);
      gap += (data_ready !== 1'b0);
    end
    chk("standby_quiet", gap, 0);
    $display("test autosleep done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
